// File: hdl/spin_cfg_pkg.sv
// Package with offsets, field positions and reset values of the configuration words
// Assumes one core clock domain and a plain strobe register port
// Function
// R1 - The reverse-drive word lives at offset 0x82, resets to zero, and every field is read/write.
// R2 - Bits 30..27 select the reverse linear acceleration code, 0.01 Hz/s at code 0 up to 10000 Hz/s at code 15.
// R3 - Bits 26..23 select the reverse quadratic acceleration code, zero at code 0 up to 10000 at code 15.
// R4 - Bits 22..20 set the braking bus current cap, 0.5 A at code 0 then 1 A steps to 7 A.
// R5 - Bits 19..10 hold the braking proportional gain, value divided by 128.
// R6 - Bits 9..0 hold the braking integral gain, value divided by 512.
// R7 - The start-up word lives at offset 0x84, resets to zero, with parity, method, ramp, align time and align current fields.
// R8 - The ramp-rate field caps current ramp in align, slow first cycle and open loop, 0.1 A/s up to no limit.
// R9 - The align current field caps current in align or slow first cycle, 0.125 A up to 8.0 A.
// R10 - Parity bits are stored as written and read back, with no check made here.
package spin_cfg_pkg;
	localparam int          ADDR_W          = 8;
	localparam int          DATA_W          = 32;
	// Printed offsets are not all multiples of four, so they are indices
	localparam logic [7:0]  REV_SETUP_IDX   = 8'h82;
	localparam logic [7:0]  SPINUP_IDX      = 8'h84;
	localparam logic [31:0] REV_SETUP_RST   = 32'h0000_0000;
	localparam logic [31:0] SPINUP_RST      = 32'h0000_0000;
	localparam int          PARITY_BIT      = 31;
	localparam int          LIN_ACC_LSB     = 27;
	localparam int          QUAD_ACC_LSB    = 23;
	localparam int          BRK_CAP_LSB     = 20;
	localparam int          BRK_KP_LSB      = 10;
	localparam int          BRK_KI_LSB      = 0;
	localparam int          METHOD_LSB      = 29;
	localparam int          RAMP_LSB        = 25;
	localparam int          ALIGN_T_LSB     = 21;
	localparam int          LOCK_CAP_LSB    = 17;
	localparam int          PROBE_RATE_LSB  = 14;
	localparam int          PROBE_THR_LSB   = 9;
	localparam int          PROBE_REL_BIT   = 8;
	localparam int          PROBE_ADV_LSB   = 6;
	localparam int          PROBE_REP_LSB   = 4;
	localparam int          OL_CAP_BIT      = 3;
	localparam int          IQ_RAMP_BIT     = 2;
	localparam int          REGEN_BIT       = 1;
	localparam int          REV_OPT_BIT     = 0;
	localparam logic [3:0]  RAMP_NO_LIMIT   = 4'hf;
endpackage : spin_cfg_pkg

// File: hdl/cfg_word_if.sv
// Interface carrying one configuration word between the bank and its word store
// Assumes both ends run on the same core clock
`timescale 1ns/1ps
interface cfg_word_if;
	logic        wr;
	logic [31:0] wdata;
	logic [31:0] word;
	modport bank  (output wr, output wdata, input word);
	modport store (input wr, input wdata, output word);
endinterface : cfg_word_if

// File: hdl/cfg_word_store.sv
// One 32-bit read/write configuration word with a reset value
// Assumes write strobes are synchronous one-cycle pulses
`timescale 1ns/1ps
module cfg_word_store #(
	parameter logic [31:0] RST_VAL = 32'h0000_0000
) (
	input  wire logic i_clk,
	input  wire logic i_rst_n,
	cfg_word_if.store port
);
	// Whole word stored as written, parity bit included
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			port.word <= RST_VAL;
		end else if (port.wr) begin
			port.word <= port.wdata; // R10
		end
	end
endmodule : cfg_word_store

// File: hdl/reverse_drive_startup_config_regs.sv
// Register bank holding the reverse-drive and start-up configuration words
// Assumes a strobe bus master that never asserts read and write together
`timescale 1ns/1ps
module reverse_drive_startup_config_regs (
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	input  wire logic [7:0]  i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [31:0] o_rdata,
	output logic      [3:0]  o_reverse_linear_accel_sel,
	output logic      [3:0]  o_reverse_quadratic_accel_sel,
	output logic      [2:0]  o_braking_bus_current_cap,
	output logic      [9:0]  o_braking_prop_gain,
	output logic      [9:0]  o_braking_integral_gain,
	output logic      [1:0]  o_spinup_method_sel,
	output logic      [3:0]  o_spinup_ramp_rate_sel,
	output logic             o_spinup_ramp_unlimited,
	output logic      [3:0]  o_rotor_lock_time_sel,
	output logic      [3:0]  o_rotor_lock_current_cap,
	output logic      [2:0]  o_position_probe_rate_sel,
	output logic      [4:0]  o_position_probe_current_thr,
	output logic             o_position_probe_release_sel,
	output logic      [1:0]  o_position_probe_advance_sel,
	output logic      [1:0]  o_position_probe_repeat_sel,
	output logic             o_openloop_current_cap_sel,
	output logic             o_torque_current_ramp_on,
	output logic             o_regen_braking_on,
	output logic             o_reverse_spin_option
);
	cfg_word_if rev_if ();
	cfg_word_if spin_if ();
	logic [31:0] reverse_spin_setup;
	logic [31:0] spinup_setup_word;
	logic [31:0] next_rdata;
	wire         hit_rev  = (i_addr == spin_cfg_pkg::REV_SETUP_IDX);
	wire         hit_spin = (i_addr == spin_cfg_pkg::SPINUP_IDX);

	// Address decode for writes
	assign rev_if.wr     = i_wr && hit_rev; // R1
	assign rev_if.wdata  = i_wdata;
	assign spin_if.wr    = i_wr && hit_spin; // R7
	assign spin_if.wdata = i_wdata;
	assign reverse_spin_setup = rev_if.word;
	assign spinup_setup_word  = spin_if.word;

	cfg_word_store #(.RST_VAL(spin_cfg_pkg::REV_SETUP_RST)) u_rev (
		.i_clk  (i_clk),
		.i_rst_n(i_rst_n),
		.port   (rev_if.store)
	);
	cfg_word_store #(.RST_VAL(spin_cfg_pkg::SPINUP_RST)) u_spin (
		.i_clk  (i_clk),
		.i_rst_n(i_rst_n),
		.port   (spin_if.store)
	);

	// Read mux; unmapped addresses return zero
	assign next_rdata = !i_rd    ? 32'h0000_0000 :
	                    hit_rev  ? reverse_spin_setup :
	                    hit_spin ? spinup_setup_word : 32'h0000_0000;

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rdata <= 32'h0000_0000;
		end else begin
			o_rdata <= next_rdata; // R10
		end
	end

	// Field selection; the flops below only copy these, so each slice is named once
	wire [3:0] lin_accel_field  = reverse_spin_setup[spin_cfg_pkg::LIN_ACC_LSB +: 4]; // R2
	wire [3:0] quad_accel_field = reverse_spin_setup[spin_cfg_pkg::QUAD_ACC_LSB +: 4]; // R3
	wire [2:0] brake_cap_field  = reverse_spin_setup[spin_cfg_pkg::BRK_CAP_LSB +: 3]; // R4
	wire [9:0] brake_kp_field   = reverse_spin_setup[spin_cfg_pkg::BRK_KP_LSB +: 10]; // R5
	wire [9:0] brake_ki_field   = reverse_spin_setup[spin_cfg_pkg::BRK_KI_LSB +: 10]; // R6
	wire [1:0] method_field     = spinup_setup_word[spin_cfg_pkg::METHOD_LSB +: 2]; // R7
	wire [3:0] ramp_field       = spinup_setup_word[spin_cfg_pkg::RAMP_LSB +: 4]; // R8
	wire       ramp_top         = (ramp_field == spin_cfg_pkg::RAMP_NO_LIMIT); // R8
	wire [3:0] lock_time_field  = spinup_setup_word[spin_cfg_pkg::ALIGN_T_LSB +: 4];
	wire [3:0] lock_cap_field   = spinup_setup_word[spin_cfg_pkg::LOCK_CAP_LSB +: 4]; // R9
	wire [2:0] probe_rate_field = spinup_setup_word[spin_cfg_pkg::PROBE_RATE_LSB +: 3];
	wire [4:0] probe_thr_field  = spinup_setup_word[spin_cfg_pkg::PROBE_THR_LSB +: 5];
	wire       probe_rel_field  = spinup_setup_word[spin_cfg_pkg::PROBE_REL_BIT];
	wire [1:0] probe_adv_field  = spinup_setup_word[spin_cfg_pkg::PROBE_ADV_LSB +: 2];
	wire [1:0] probe_rep_field  = spinup_setup_word[spin_cfg_pkg::PROBE_REP_LSB +: 2];
	wire       ol_cap_field     = spinup_setup_word[spin_cfg_pkg::OL_CAP_BIT];
	wire       iq_ramp_field    = spinup_setup_word[spin_cfg_pkg::IQ_RAMP_BIT];
	wire       regen_field      = spinup_setup_word[spin_cfg_pkg::REGEN_BIT];
	wire       rev_opt_field    = spinup_setup_word[spin_cfg_pkg::REV_OPT_BIT];

	// Field outputs registered so the algorithm sees clean flops; one cycle behind the word
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_reverse_linear_accel_sel    <= 4'h0;
			o_reverse_quadratic_accel_sel <= 4'h0;
			o_braking_bus_current_cap     <= 3'h0;
			o_braking_prop_gain           <= 10'h000;
			o_braking_integral_gain       <= 10'h000;
			o_spinup_method_sel           <= 2'h0;
			o_spinup_ramp_rate_sel        <= 4'h0;
			o_spinup_ramp_unlimited       <= 1'b0;
			o_rotor_lock_time_sel         <= 4'h0;
			o_rotor_lock_current_cap      <= 4'h0;
			o_position_probe_rate_sel     <= 3'h0;
			o_position_probe_current_thr  <= 5'h00;
			o_position_probe_release_sel  <= 1'b0;
			o_position_probe_advance_sel  <= 2'h0;
			o_position_probe_repeat_sel   <= 2'h0;
			o_openloop_current_cap_sel    <= 1'b0;
			o_torque_current_ramp_on      <= 1'b0;
			o_regen_braking_on            <= 1'b0;
			o_reverse_spin_option         <= 1'b0;
		end else begin
			o_reverse_linear_accel_sel    <= lin_accel_field; // R2
			o_reverse_quadratic_accel_sel <= quad_accel_field; // R3
			o_braking_bus_current_cap     <= brake_cap_field; // R4
			o_braking_prop_gain           <= brake_kp_field; // R5
			o_braking_integral_gain       <= brake_ki_field; // R6
			o_spinup_method_sel           <= method_field; // R7
			o_spinup_ramp_rate_sel        <= ramp_field; // R8
			o_spinup_ramp_unlimited       <= ramp_top; // R8
			o_rotor_lock_time_sel         <= lock_time_field;
			o_rotor_lock_current_cap      <= lock_cap_field; // R9
			o_position_probe_rate_sel     <= probe_rate_field;
			o_position_probe_current_thr  <= probe_thr_field;
			o_position_probe_release_sel  <= probe_rel_field;
			o_position_probe_advance_sel  <= probe_adv_field;
			o_position_probe_repeat_sel   <= probe_rep_field;
			o_openloop_current_cap_sel    <= ol_cap_field;
			o_torque_current_ramp_on      <= iq_ramp_field;
			o_regen_braking_on            <= regen_field;
			o_reverse_spin_option         <= rev_opt_field;
		end
	end

	// Checks on write-to-read and write-to-field behaviour
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	// Read straight after write must see the new word; no bypass path is needed
	rev_readback_a: assert property (i_wr && hit_rev ##1 i_rd && hit_rev // R1
		|=> o_rdata == $past(i_wdata, 2))
		else $error("Reverse word read back differs from write");
	spin_readback_a: assert property (i_wr && hit_spin ##1 i_rd && hit_spin // R7
		|=> o_rdata == $past(i_wdata, 2))
		else $error("Start-up word read back differs from write");
	rev_parity_a: assert property (i_wr && hit_rev ##1 i_rd && hit_rev // R10
		|=> o_rdata[31] == $past(i_wdata[31], 2))
		else $error("Reverse parity bit not kept");
	parity_kept_a: assert property (i_wr && hit_spin ##1 i_rd && hit_spin // R10
		|=> o_rdata[31] == $past(i_wdata[31], 2))
		else $error("Parity bit not kept");

	// Reverse-drive fields appear two edges after the write edge
	lin_accel_field_a: assert property (i_wr && hit_rev // R2
		|=> ##1 o_reverse_linear_accel_sel == $past(i_wdata[30:27], 2))
		else $error("Linear accel field wrong");
	quad_accel_field_a: assert property (i_wr && hit_rev // R3
		|=> ##1 o_reverse_quadratic_accel_sel == $past(i_wdata[26:23], 2))
		else $error("Quadratic accel field wrong");
	brake_cap_field_a: assert property (i_wr && hit_rev // R4
		|=> ##1 o_braking_bus_current_cap == $past(i_wdata[22:20], 2))
		else $error("Braking current cap field wrong");
	brake_kp_field_a: assert property (i_wr && hit_rev // R5
		|=> ##1 o_braking_prop_gain == $past(i_wdata[19:10], 2))
		else $error("Braking proportional gain wrong");
	brake_ki_field_a: assert property (i_wr && hit_rev // R6
		|=> ##1 o_braking_integral_gain == $past(i_wdata[9:0], 2))
		else $error("Braking integral gain wrong");

	// Start-up fields, same latency; the bit positions are checked independently of the slices
	method_field_a: assert property (i_wr && hit_spin // R7
		|=> ##1 o_spinup_method_sel == $past(i_wdata[30:29], 2))
		else $error("Start-up method field wrong");
	ramp_sel_field_a: assert property (i_wr && hit_spin // R8
		|=> ##1 o_spinup_ramp_rate_sel == $past(i_wdata[28:25], 2))
		else $error("Ramp rate field wrong");
	ramp_unlimited_a: assert property (i_wr && hit_spin // R8
		|=> ##1 o_spinup_ramp_unlimited == ($past(i_wdata[28:25], 2) == 4'hf))
		else $error("Ramp unlimited flag wrong");
	lock_time_field_a: assert property (i_wr && hit_spin // R7
		|=> ##1 o_rotor_lock_time_sel == $past(i_wdata[24:21], 2))
		else $error("Align time field wrong");
	lock_cap_field_a: assert property (i_wr && hit_spin // R9
		|=> ##1 o_rotor_lock_current_cap == $past(i_wdata[20:17], 2))
		else $error("Lock current cap field wrong");
	probe_fields_a: assert property (i_wr && hit_spin // R7
		|=> ##1 {o_position_probe_rate_sel, o_position_probe_current_thr,
		o_position_probe_release_sel, o_position_probe_advance_sel,
		o_position_probe_repeat_sel} == $past(i_wdata[16:4], 2))
		else $error("Position probe fields wrong");
	enable_bits_a: assert property (i_wr && hit_spin // R7
		|=> ##1 {o_openloop_current_cap_sel, o_torque_current_ramp_on, o_regen_braking_on,
		o_reverse_spin_option} == $past(i_wdata[3:0], 2))
		else $error("Start-up enable bits wrong");

	// Fields must not move unless their own word was written; catches a crossed decode
	rev_hold_a: assert property (!(i_wr && hit_rev) // R1
		|=> ##1 $stable({o_reverse_linear_accel_sel, o_reverse_quadratic_accel_sel,
		o_braking_bus_current_cap, o_braking_prop_gain, o_braking_integral_gain}))
		else $error("Reverse fields moved without a write");
	spin_hold_a: assert property (!(i_wr && hit_spin) // R7
		|=> ##1 $stable({o_spinup_method_sel, o_spinup_ramp_rate_sel, o_spinup_ramp_unlimited,
		o_rotor_lock_time_sel, o_rotor_lock_current_cap, o_position_probe_rate_sel,
		o_position_probe_current_thr, o_position_probe_release_sel,
		o_position_probe_advance_sel, o_position_probe_repeat_sel,
		o_openloop_current_cap_sel, o_torque_current_ramp_on, o_regen_braking_on,
		o_reverse_spin_option}))
		else $error("Start-up fields moved without a write");

	// Read data is zero except in the cycle after a mapped read
	unmapped_zero_a: assert property (i_rd && !hit_rev && !hit_spin |=> o_rdata == 32'h0) // R1
		else $error("Unmapped read not zero");
	rdata_idle_a: assert property (!i_rd |=> o_rdata == 32'h0) // R1
		else $error("Read data not zero outside a read");

	// Main scenarios the bench is expected to reach
	rev_write_cov: cover property (i_wr && hit_rev ##1 i_rd && hit_rev);
	spin_write_cov: cover property (i_wr && hit_spin ##1 i_rd && hit_spin);
	no_limit_cov: cover property (o_spinup_ramp_unlimited);
	parity_cov: cover property (i_rd && hit_spin ##1 o_rdata[31]);
	unmapped_cov: cover property (i_wr && !hit_rev && !hit_spin);
endmodule : reverse_drive_startup_config_regs

// File: testbench/tb.sv
// Self-checking bench for the reverse-drive and start-up configuration bank
// Assumes the plain strobe port, with read data standing only in the cycle after the read strobe
`timescale 1ns/1ps
module tb;
	logic        i_clk   = 1'b0;
	logic        i_rst_n = 1'b0;
	logic [7:0]  i_addr  = 8'h00;
	logic [31:0] i_wdata = 32'h0000_0000;
	logic        i_wr    = 1'b0;
	logic        i_rd    = 1'b0;
	logic [31:0] o_rdata;
	logic [3:0]  lin, quad, rate, ltime, lcap;
	logic [2:0]  bcap, prate;
	logic [9:0]  kp, ki;
	logic [4:0]  thr;
	logic [1:0]  meth, adv, rep;
	logic        unlim, rel, olc, iqr, regen, revo;
	int          n_fail = 0;
	int          checks = 0;
	int          cycles = 0;
	logic [31:0] pats [2] = '{32'hd5a5_3c96, 32'h2a5a_c369};
	logic [7:0]  bad [4] = '{8'h83, 8'h02, 8'h04, 8'h86};

	reverse_drive_startup_config_regs u_dut (
		.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.o_reverse_linear_accel_sel(lin), .o_reverse_quadratic_accel_sel(quad),
		.o_braking_bus_current_cap(bcap), .o_braking_prop_gain(kp),
		.o_braking_integral_gain(ki), .o_spinup_method_sel(meth),
		.o_spinup_ramp_rate_sel(rate), .o_spinup_ramp_unlimited(unlim),
		.o_rotor_lock_time_sel(ltime), .o_rotor_lock_current_cap(lcap),
		.o_position_probe_rate_sel(prate), .o_position_probe_current_thr(thr),
		.o_position_probe_release_sel(rel), .o_position_probe_advance_sel(adv),
		.o_position_probe_repeat_sel(rep), .o_openloop_current_cap_sel(olc),
		.o_torque_current_ramp_on(iqr), .o_regen_braking_on(regen),
		.o_reverse_spin_option(revo)
	);

	// 10 MHz core clock
	always #50 i_clk = ~i_clk;

	// Hang guard: the whole sequence needs well under a thousand cycles
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 3000) begin
			n_fail++;
			test_done();
		end
	end

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask

	// One-cycle write strobe, launched just after an edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_wr    <= 1'b1;
		i_addr  <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask

	// Data is taken mid-cycle after the strobe edge, the only cycle it stands
	task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
		@(posedge i_clk);
		i_rd   <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		@(negedge i_clk);
		chk(name, exp, o_rdata);
	endtask

	// Write then read with no idle cycle between the strobes
	task automatic wrrdchk(input string name, input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_wr    <= 1'b1;
		i_addr  <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		@(negedge i_clk);
		chk(name, d, o_rdata);
	endtask

	// Reset edges are launched on a rising edge like every other input
	task automatic do_reset();
		@(posedge i_clk);
		i_rst_n <= 1'b0;
		repeat (16) @(posedge i_clk);
		i_rst_n <= 1'b1;
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial begin
		do_reset();
		rdchk("reverse reset", 8'h82, 32'h0000_0000);
		rdchk("spinup reset", 8'h84, 32'h0000_0000);
		chk("reverse fields reset", 32'h0000_0000, {1'b0, lin, quad, bcap, kp, ki});
		chk("spinup fields reset", 32'h0000_0000, {1'b0, meth, rate, ltime, lcap, prate,
			thr, rel, adv, rep, olc, iqr, regen, revo});
		$display("test reset done");
		// Both polarities of every bit read back, parity included, and of bits 30..0 seen on the fields
		foreach (pats[i]) begin
			wr(8'h82, pats[i]);
			wr(8'h84, ~pats[i]);
			rdchk("reverse word", 8'h82, pats[i]);
			@(negedge i_clk);
			chk("rdata after read", 32'h0000_0000, o_rdata);
			rdchk("spinup word", 8'h84, ~pats[i]);
			chk("reverse fields", {1'b0, pats[i][30:0]}, {1'b0, lin, quad, bcap, kp, ki});
			chk("spinup fields", {1'b0, ~pats[i][30:0]}, {1'b0, meth, rate, ltime, lcap, prate,
				thr, rel, adv, rep, olc, iqr, regen, revo});
		end
		$display("test patterns done");
		// Every ramp code; only the top code lifts the limit
		for (int c = 0; c < 16; c++) begin
			wr(8'h84, {3'h0, c[3:0], 25'h0});
			rdchk("ramp word", 8'h84, {3'h0, c[3:0], 25'h0});
			chk("ramp unlimited", {31'h0, c == 15}, {31'h0, unlim});
		end
		$display("test ramp done");
		// Near-miss addresses must neither store nor answer
		foreach (bad[i]) begin
			wr(bad[i], 32'hffff_ffff);
			rdchk("unmapped read", bad[i], 32'h0000_0000);
		end
		rdchk("reverse kept", 8'h82, pats[1]);
		rdchk("spinup kept", 8'h84, {3'h0, 4'hf, 25'h0});
		$display("test unmapped done");
		// Second reset in mid-run clears both words
		do_reset();
		rdchk("reverse rereset", 8'h82, 32'h0000_0000);
		rdchk("spinup rereset", 8'h84, 32'h0000_0000);
		chk("unlimited rereset", 32'h0000_0000, {31'h0, unlim});
		chk("reverse fields rereset", 32'h0000_0000, {1'b0, lin, quad, bcap, kp, ki});
		chk("spinup fields rereset", 32'h0000_0000, {1'b0, meth, rate, ltime, lcap, prate,
			thr, rel, adv, rep, olc, iqr, regen, revo});
		$display("test rereset done");
		// Read straight after write sees the new word, parity bit set on both
		wrrdchk("reverse back to back", 8'h82, 32'hc000_0201);
		wrrdchk("spinup back to back", 8'h84, 32'ha000_0003);
		chk("reverse fields b2b", 32'h4000_0201, {1'b0, lin, quad, bcap, kp, ki});
		chk("spinup fields b2b", 32'h2000_0003, {1'b0, meth, rate, ltime, lcap, prate,
			thr, rel, adv, rep, olc, iqr, regen, revo});
		$display("test back to back done");
		test_done();
	end
endmodule // tb
